// [hw/psacd_pkg.sv]
// Constants for the PHY status, auto-negotiation and cable-diagnostic register view.
// Assumes a 100 MHz device clock and the banked 16-bit host register port.
// What this block does
// - Basic status bit 15 reads zero; no four-pair 100 Mb/s ability; read-only.
// - Basic status bits 14 and 13 read one: 100BASE-TX full and half ability.
// - Basic status bits 12 and 11 read one: 10BASE-T full and half ability.
// - Basic status bit 5 shows auto-negotiation finished; resets zero; read-only.
// - Basic status bit 3 always one; bit 0 reads zero; both read-only.
// - Advertisement bit 10 writable, resets one, selects advertising pause ability.
// - Advertisement bits 8 to 5 writable, reset one, select advertised duplex abilities.
// - Partner bit 10 read-only, resets zero, shows partner pause ability.
// - Partner bits 8 to 5 read-only, reset zero, show partner duplex abilities.
// - Writing one to diagnostic bit 15 starts a test; device clears it when done.
// - Diagnostic bit 15 at zero means results are valid; software waits for it.
// - Result field 14-13: 00 normal, 01 open, 10 short; read-only.
// - Result code 11 when the cable test itself could not complete.
// - Diagnostic bit 12 read-only, set for a short closer than ten metres.
// - Diagnostic bits 8-0 hold the unsigned fault distance count, about 0.4 m each.
// - Auto-negotiation enable control bit resets one; cleared means forced speed and duplex.
// - Writing one to restart control bit begins a new auto-negotiation exchange.
package psacd_pkg;

	// Bank numbers and byte offsets of the host register port.
	localparam logic [5:0] BANK_PHY_MII = 6'h2D;
	localparam logic [5:0] BANK_CABLE_DIAG = 6'h2F;
	localparam logic [7:0] OFF_BASIC_CTRL = 8'h00;
	localparam logic [7:0] OFF_BASIC_STATUS = 8'h02;
	localparam logic [7:0] OFF_ID_LOW = 8'h04;
	localparam logic [7:0] OFF_ID_HIGH = 8'h06;
	localparam logic [7:0] OFF_ADVERT = 8'h08;
	localparam logic [7:0] OFF_PARTNER = 8'h0A;
	localparam logic [7:0] OFF_DIAG = 8'h00;

	// Identifier values; the defaults are arbitrary neutral values.
	localparam logic [15:0] ID_LOW_DEFAULT = 16'hA5C3;
	localparam logic [15:0] ID_HIGH_DEFAULT = 16'h3C5A;

	// Basic control field positions and reset values.
	localparam int CTRL_AN_EN_BIT = 12;
	localparam int CTRL_AN_RESTART_BIT = 9;
	localparam logic CTRL_AN_EN_RESET = 1'b1;

	// Basic status field positions.
	localparam int ST_T4_BIT = 15;
	localparam int ST_100FD_BIT = 14;
	localparam int ST_100HD_BIT = 13;
	localparam int ST_10FD_BIT = 12;
	localparam int ST_10HD_BIT = 11;
	localparam int ST_AN_DONE_BIT = 5;
	localparam int ST_AN_ABLE_BIT = 3;
	localparam int ST_LINK_BIT = 2;
	localparam int ST_EXT_BIT = 0;

	// Advertisement and partner ability field positions.
	localparam int ADV_PAUSE_BIT = 10;
	localparam int ADV_ABIL_LSB = 5;
	localparam int ADV_ABIL_W = 4;
	localparam logic ADV_PAUSE_RESET = 1'b1;
	localparam logic [3:0] ADV_ABIL_RESET = 4'hF;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;

	// Cable diagnostic field positions and result codes.
	localparam int DG_START_BIT = 15;
	localparam int DG_RES_LSB = 13;
	localparam int DG_NEAR_BIT = 12;
	localparam int DG_COUNT_W = 9;
	localparam logic [1:0] DG_RES_NORMAL = 2'h0;
	localparam logic [1:0] DG_RES_OPEN = 2'h1;
	localparam logic [1:0] DG_RES_SHORT = 2'h2;
	localparam logic [1:0] DG_RES_FAIL = 2'h3;

	// Time a test may take before it is declared failed.
	localparam int CLK_PERIOD_NS = 10;
	localparam int DIAG_TIMEOUT_NS = 10000000;
	localparam int DIAG_TIMEOUT_CYCLES = DIAG_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int DIAG_CNT_W = 24;

	// Width of the synchronised status vector from the line circuitry.
	localparam int SYNC_W = 20;

	typedef enum logic [0:0] {DIAG_IDLE, DIAG_RUN} psacd_diag_state_type;

endpackage

// [hw/psacd_diag_if.sv]
// Interface between the register view and the cable-diagnostic sequencer.
// Assumes both ends share the device clock.
`timescale 1ns/1ps
interface psacd_diag_if;
	logic start;
	logic busy;
	logic [1:0] result;
	logic near_short;
	logic [8:0] fault_count;

	// The sequencer owns test state; the register view only requests starts.
	modport seq (input start, output busy, output result, output near_short, output fault_count);
	modport regs (output start, input busy, input result, input near_short, input fault_count);
endinterface

// [hw/psacd_diag_seq.sv]
// Cable-diagnostic sequencer: runs one test and captures its outcome.
// Assumes line-side inputs are already synchronised to clk.
`timescale 1ns/1ps
module psacd_diag_seq import psacd_pkg::*; #(
	parameter int TIMEOUT_CYCLES = DIAG_TIMEOUT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register side.
	psacd_diag_if.seq dg,
	// Line side.
	input wire logic line_done,
	input wire logic [1:0] line_result,
	input wire logic line_near_short,
	input wire logic [8:0] line_count,
	output logic line_run
);

	psacd_diag_state_type state_reg, state_next;
	logic [DIAG_CNT_W-1:0] timer_reg, timer_next;
	logic [1:0] result_reg, result_next;
	logic near_reg, near_next;
	logic [8:0] count_reg, count_next;

	////////////////////////////////////////////////////////////////////////////////
	// Next state: a start is taken only when idle, so a test in flight cannot be restarted.
	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		result_next = result_reg;
		near_next = near_reg;
		count_next = count_reg;
		case (state_reg)
			DIAG_IDLE: begin
				if (dg.start) begin
					state_next = DIAG_RUN;
					timer_next = '0;
				end
			end
			DIAG_RUN: begin
				if (line_done) begin
					state_next = DIAG_IDLE;
					result_next = line_result;
					near_next = line_near_short;
					count_next = line_count;
				end else if (timer_reg == DIAG_CNT_W'(TIMEOUT_CYCLES - 1)) begin
					// A line that never answers must not hang software polling the start bit.
					state_next = DIAG_IDLE;
					result_next = DG_RES_FAIL;
					near_next = 1'b0;
					count_next = '0;
				end else begin
					timer_next = timer_reg + DIAG_CNT_W'(1);
				end
			end
			default: state_next = DIAG_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DIAG_IDLE;
			timer_reg <= '0;
			result_reg <= DG_RES_NORMAL;
			near_reg <= 1'b0;
			count_reg <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			result_reg <= result_next;
			near_reg <= near_next;
			count_reg <= count_next;
		end
	end

	// Busy drives the start bit read-back and the line request.
	assign dg.busy = (state_reg == DIAG_RUN);
	assign dg.result = result_reg;
	assign dg.near_short = near_reg;
	assign dg.fault_count = count_reg;
	assign line_run = (state_reg == DIAG_RUN);

endmodule

// [hw/psacd_regs.sv]
// Host-visible PHY status, identifier, advertisement, partner and cable-diagnostic registers.
// Assumes a banked 16-bit host port on clk and status levels from the analog line circuitry.
`timescale 1ns/1ps
module psacd_regs import psacd_pkg::*; #(
	parameter logic [15:0] ID_LOW = ID_LOW_DEFAULT,
	parameter logic [15:0] ID_HIGH = ID_HIGH_DEFAULT,
	parameter int TIMEOUT_CYCLES = DIAG_TIMEOUT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Host register port.
	input wire logic [5:0] reg_bank,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// Line status inputs, asynchronous to clk.
	input wire logic line_link_up,
	input wire logic line_an_done,
	input wire logic line_lp_pause,
	input wire logic [3:0] line_lp_abil,
	input wire logic line_diag_done,
	input wire logic [1:0] line_diag_result,
	input wire logic line_diag_near_short,
	input wire logic [8:0] line_diag_count,
	// Line control outputs.
	output logic an_enable,
	output logic an_restart,
	output logic adv_pause,
	output logic [3:0] adv_abil,
	output logic diag_run
);

	logic rst_s1_reg, rst_n_sync;
	logic [SYNC_W-1:0] sync_in, sync_s1_reg, sync_s2_reg;
	logic link_s, an_done_s, lp_pause_s, dg_done_s, dg_near_s;
	logic [3:0] lp_abil_s;
	logic [1:0] dg_res_s;
	logic [8:0] dg_count_s;
	logic an_en_reg, an_en_next;
	logic restart_reg, restart_next;
	logic pause_reg, pause_next;
	logic [3:0] abil_reg, abil_next;
	logic [15:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic start_req;
	logic [15:0] ctrl_word, status_word, adv_word, partner_word, diag_word;
	logic hit_mii, hit_diag;
	psacd_diag_if dg ();

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops so no flop leaves reset on a ragged edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line status passes two flops per bit; only the second stage is read.
	// Multi-bit fields are sampled per bit, so the line side must hold them stable around done.
	assign sync_in = {line_link_up, line_an_done, line_lp_pause, line_lp_abil, line_diag_done,
		line_diag_result, line_diag_near_short, line_diag_count};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n_sync) begin
				if (!rst_n_sync) begin
					sync_s1_reg[gi] <= 1'b0;
					sync_s2_reg[gi] <= 1'b0;
				end else begin
					sync_s1_reg[gi] <= sync_in[gi];
					sync_s2_reg[gi] <= sync_s1_reg[gi];
				end
			end
		end
	endgenerate

	assign {link_s, an_done_s, lp_pause_s, lp_abil_s, dg_done_s, dg_res_s, dg_near_s, dg_count_s} = sync_s2_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Diagnostic sequencer.
	psacd_diag_seq #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_diag (
		.clk(clk),
		.rst_n(rst_n_sync),
		.dg(dg.seq),
		.line_done(dg_done_s),
		.line_result(dg_res_s),
		.line_near_short(dg_near_s),
		.line_count(dg_count_s),
		.line_run(diag_run)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode for the two banks.
	assign hit_mii = (reg_bank == BANK_PHY_MII);
	assign hit_diag = (reg_bank == BANK_CABLE_DIAG) && (reg_addr == OFF_DIAG);
	assign start_req = reg_wr && hit_diag && reg_wdata[DG_START_BIT];
	assign dg.start = start_req;

	// Read-back words; every bit not named here reads zero.
	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_AN_EN_BIT] = an_en_reg;
		status_word = '0;
		status_word[ST_T4_BIT] = 1'b0;
		status_word[ST_100FD_BIT] = 1'b1;
		status_word[ST_100HD_BIT] = 1'b1;
		status_word[ST_10FD_BIT] = 1'b1;
		status_word[ST_10HD_BIT] = 1'b1;
		status_word[ST_AN_DONE_BIT] = an_done_s;
		status_word[ST_AN_ABLE_BIT] = 1'b1;
		status_word[ST_EXT_BIT] = 1'b0;
		status_word[ST_LINK_BIT] = link_s;
		adv_word = {11'h000, SELECTOR_8023};
		adv_word[ADV_PAUSE_BIT] = pause_reg;
		adv_word[ADV_ABIL_LSB +: ADV_ABIL_W] = abil_reg;
		partner_word = {11'h000, SELECTOR_8023};
		partner_word[ADV_PAUSE_BIT] = lp_pause_s;
		partner_word[ADV_ABIL_LSB +: ADV_ABIL_W] = lp_abil_s;
		diag_word = '0;
		diag_word[DG_START_BIT] = dg.busy;
		diag_word[DG_RES_LSB +: 2] = dg.result;
		diag_word[DG_NEAR_BIT] = dg.near_short;
		diag_word[DG_COUNT_W-1:0] = dg.fault_count;
	end

	////////////////////////////////////////////////////////////////////////////////
	// In the MII bank, writes reach only the control and advertisement fields; all else there ignores them.
	always_comb begin
		an_en_next = an_en_reg;
		restart_next = 1'b0;
		pause_next = pause_reg;
		abil_next = abil_reg;
		if (reg_wr && hit_mii) begin
			case (reg_addr)
				OFF_BASIC_CTRL: begin
					an_en_next = reg_wdata[CTRL_AN_EN_BIT];
					restart_next = reg_wdata[CTRL_AN_RESTART_BIT];
				end
				OFF_ADVERT: begin
					pause_next = reg_wdata[ADV_PAUSE_BIT];
					abil_next = reg_wdata[ADV_ABIL_LSB +: ADV_ABIL_W];
				end
				default: begin
					an_en_next = an_en_reg;
				end
			endcase
		end
	end

	// Read data is registered one cycle after the read strobe; unmapped offsets give zero.
	always_comb begin
		rvalid_next = reg_rd;
		rdata_next = '0;
		if (reg_rd && hit_mii) begin
			case (reg_addr)
				OFF_BASIC_CTRL: rdata_next = ctrl_word;
				OFF_BASIC_STATUS: rdata_next = status_word;
				OFF_ID_LOW: rdata_next = ID_LOW;
				OFF_ID_HIGH: rdata_next = ID_HIGH;
				OFF_ADVERT: rdata_next = adv_word;
				OFF_PARTNER: rdata_next = partner_word;
				default: rdata_next = '0;
			endcase
		end else if (reg_rd && hit_diag) begin
			rdata_next = diag_word;
		end
	end

	// Register stage for control, advertisement and read data.
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			an_en_reg <= CTRL_AN_EN_RESET;
			restart_reg <= 1'b0;
			pause_reg <= ADV_PAUSE_RESET;
			abil_reg <= ADV_ABIL_RESET;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			an_en_reg <= an_en_next;
			restart_reg <= restart_next;
			pause_reg <= pause_next;
			abil_reg <= abil_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs come straight from flops; restart is a one-cycle pulse per write of one.
	assign an_enable = an_en_reg;
	assign an_restart = restart_reg;
	assign adv_pause = pause_reg;
	assign adv_abil = abil_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;

endmodule

// [testbench/psacd_regs_asserts.sv]
// Checker for the PHY register view, watching only the top module ports.
// Assumes requests stay idle until the synchronised reset has been released.
`timescale 1ns/1ps
module psacd_regs_chk import psacd_pkg::*; #(
	parameter logic [15:0] ID_LOW = ID_LOW_DEFAULT,
	parameter int TIMEOUT_CYCLES = DIAG_TIMEOUT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Host port.
	input wire logic [5:0] reg_bank,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// Line side.
	input wire logic line_diag_done,
	input wire logic an_enable,
	input wire logic an_restart,
	input wire logic adv_pause,
	input wire logic [3:0] adv_abil,
	input wire logic diag_run
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic mii, rd_st, rd_id, wr_adv, wr_ctl, rst_req, wr_dg, rd_dg;
	logic [31:0] run_cnt_reg, run_cnt_next;
	////////////////////////////////
	// Decoded requests keep the properties short.
	assign mii = reg_bank == BANK_PHY_MII;
	assign rd_st = reg_rd && mii && reg_addr == OFF_BASIC_STATUS;
	assign rd_id = reg_rd && mii && reg_addr == OFF_ID_LOW;
	assign wr_adv = reg_wr && mii && reg_addr == OFF_ADVERT;
	assign wr_ctl = reg_wr && mii && reg_addr == OFF_BASIC_CTRL;
	assign rst_req = wr_ctl && reg_wdata[9];
	assign wr_dg = reg_wr && reg_bank == BANK_CABLE_DIAG && reg_addr == OFF_DIAG;
	assign rd_dg = reg_rd && reg_bank == BANK_CABLE_DIAG && reg_addr == OFF_DIAG;
	// Counts cycles of one test, because a hung test would otherwise never show.
	always_comb begin
		run_cnt_next = diag_run ? run_cnt_reg + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_cnt_reg <= 32'h0;
		end else begin
			run_cnt_reg <= run_cnt_next;
		end
	end
	chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	chk_status_fixed: assert property (rd_st |=> reg_rdata[15:11] == 5'h0F && reg_rdata[10:6] == 5'h00 &&
		reg_rdata[4:3] == 2'h1 && reg_rdata[1:0] == 2'h0) else $error("status constant bits wrong");
	chk_id_low: assert property (rd_id |=> reg_rdata == ID_LOW) else $error("id low wrong");
	chk_adv_update: assert property (wr_adv |=> adv_pause == $past(reg_wdata[10]) &&
		adv_abil == $past(reg_wdata[8:5])) else $error("advert outputs not updated");
	chk_an_enable: assert property (wr_ctl |=> an_enable == $past(reg_wdata[12])) else $error("an enable wrong");
	chk_restart_cause: assert property (rst_req |=> an_restart) else $error("restart missing");
	chk_restart_only: assert property (an_restart |-> $past(rst_req)) else $error("restart unasked");
	chk_diag_start: assert property (wr_dg && reg_wdata[15] && !diag_run |=> diag_run) else $error("no start");
	chk_diag_busy: assert property (rd_dg |=> reg_rdata[15] == $past(diag_run)) else $error("busy bit wrong");
	chk_diag_clear: assert property (line_diag_done && diag_run |-> ##[1:4] !diag_run) else $error("no clear");
	chk_diag_bound: assert property (run_cnt_reg <= TIMEOUT_CYCLES + 3) else $error("test ran too long");
	cover property (wr_dg && reg_wdata[15]);
	cover property (rst_req);
	cover property (wr_adv);
endmodule
bind psacd_regs psacd_regs_chk #(.ID_LOW(ID_LOW), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk, .rstn, .reg_bank,
	.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .line_diag_done, .an_enable, .an_restart,
	.adv_pause, .adv_abil, .diag_run);

// [testbench/psacd_line_model.sv]
// Line-side model: answers a cable test after a delay chosen by the bench.
// Assumes the bench sets delay and outcome before each start.
`timescale 1ns/1ps
module psacd_line_model (
	// Clock and request.
	input wire logic clk,
	input wire logic diag_run,
	// Outcome chosen by the bench.
	input wire logic [7:0] delay,
	input wire logic hang,
	input wire logic [1:0] res,
	input wire logic near,
	input wire logic [8:0] cnt,
	// Line answer.
	output logic done,
	output logic [1:0] result,
	output logic near_short,
	output logic [8:0] count
);
	logic [7:0] age;
	////////////////////////////////
	initial begin
		age = 8'h00;
		done = 1'h0;
	end
	// Done stands until the test request drops; a hung line never answers.
	always @(posedge clk) begin
		age <= diag_run ? age + 8'h01 : 8'h00;
		done <= diag_run && !hang && age >= delay;
	end
	// Outside an answer the fields show the inverse, so stale values are never trusted.
	assign result = done ? res : ~res;
	assign near_short = done ? near : ~near;
	assign count = done ? cnt : ~cnt;
endmodule

// [testbench/psacd_regs_tb_top.sv]
// Self-checking bench for the PHY register view.
// Assumes a shortened test timeout and a line model on the diagnostic pins.
`timescale 1ns/1ps
module psacd_regs_tb_top import psacd_pkg::*;;
	localparam int TMO = 50;
	logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, link = 1'h0, an = 1'h0, lpp = 1'h0, hang = 1'h0;
	logic mnear = 1'h0, rvalid, dd, dnear, an_en, an_rs, apause, drun;
	logic [5:0] bank = 6'h00;
	logic [7:0] addr = 8'h00, dly = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, got;
	logic [3:0] lpa = 4'h0, aabil;
	logic [1:0] mres = 2'h0, dres;
	logic [8:0] mcnt = 9'h000, dcnt;
	integer seed = 12, mismatches = 0, checks = 0, i, k, n;
	always #5 clk = ~clk;
	psacd_regs #(.TIMEOUT_CYCLES(TMO)) DUT (.clk(clk), .rstn(rstn), .reg_bank(bank), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .line_link_up(link),
		.line_an_done(an), .line_lp_pause(lpp), .line_lp_abil(lpa), .line_diag_done(dd), .line_diag_result(dres),
		.line_diag_near_short(dnear), .line_diag_count(dcnt), .an_enable(an_en), .an_restart(an_rs),
		.adv_pause(apause), .adv_abil(aabil), .diag_run(drun));
	psacd_line_model u_line (.clk(clk), .diag_run(drun), .delay(dly), .hang(hang), .res(mres), .near(mnear),
		.cnt(mcnt), .done(dd), .result(dres), .near_short(dnear), .count(dcnt));
	////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks = checks + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One request held for one clock; read data is taken in the following cycle.
	task automatic req(input logic w, input logic [5:0] b, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		bank = b;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'h0;
		rd = 1'h0;
		got = rdata;
		chk("rvalid", {15'h0000, !w}, {15'h0000, rvalid});
	endtask
	task automatic rc(input logic [5:0] b, input logic [7:0] a, input logic [15:0] exp);
		req(1'h0, b, a, 16'h0000);
		chk($sformatf("reg %h_%h", b, a), exp, got);
	endtask
	// Expected words, built from the field layout.
	function automatic logic [15:0] exp_st(input logic l, input logic a);
		return {5'h0F, 5'h00, a, 2'h1, l, 2'h0};
	endfunction
	function automatic logic [15:0] exp_adv(input logic [15:0] w);
		return {5'h00, w[10], 1'h0, w[8:5], SELECTOR_8023};
	endfunction
	////////////////////////////////
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'h1;
		repeat (4) @(negedge clk);
		chk("line outs", 16'h003F, {10'h000, an_en, apause, aabil});
		rc(BANK_PHY_MII, OFF_BASIC_STATUS, 16'h7808);
		rc(BANK_PHY_MII, OFF_ID_HIGH, ID_HIGH_DEFAULT);
		rc(BANK_PHY_MII, OFF_ADVERT, 16'h05E1);
		rc(BANK_PHY_MII, OFF_PARTNER, 16'h0001);
		rc(BANK_PHY_MII, OFF_BASIC_CTRL, 16'h1000);
		rc(BANK_CABLE_DIAG, OFF_DIAG, 16'h0000);
		rc(BANK_PHY_MII, 8'h0C, 16'h0000);
		$display("test reset done");
		// Random line status and advertisement, with writes to read-only words mixed in.
		for (i = 0; i < 12; i++) begin
			n = $random(seed);
			{link, an, lpp, lpa} = n[6:0];
			req(1'h1, BANK_PHY_MII, OFF_ADVERT, n[31:16]);
			req(1'h1, BANK_PHY_MII, OFF_BASIC_STATUS, 16'hFFFF);
			req(1'h1, BANK_PHY_MII, OFF_ID_LOW, 16'h0000);
			req(1'h1, BANK_PHY_MII, OFF_PARTNER, 16'hFFFF);
			rc(BANK_PHY_MII, OFF_BASIC_STATUS, exp_st(n[6], n[5]));
			rc(BANK_PHY_MII, OFF_ID_LOW, ID_LOW_DEFAULT);
			rc(BANK_PHY_MII, OFF_ADVERT, exp_adv(n[31:16]));
			rc(BANK_PHY_MII, OFF_PARTNER, {5'h00, n[4], 1'h0, n[3:0], 5'h01});
			chk("adv outs", {11'h000, n[26], n[24:21]}, {11'h000, apause, aabil});
		end
		$display("test status done");
		// Restart pulses once and reads back as zero.
		req(1'h1, BANK_PHY_MII, OFF_BASIC_CTRL, 16'hEFFF);
		chk("restart", 16'h0001, {15'h0000, an_rs});
		@(negedge clk);
		chk("restart end", 16'h0000, {15'h0000, an_rs});
		rc(BANK_PHY_MII, OFF_BASIC_CTRL, 16'h0000);
		req(1'h1, BANK_PHY_MII, OFF_BASIC_CTRL, 16'h1000);
		chk("an enable", 16'h0001, {15'h0000, an_en});
		// A write and a read in one cycle return the word as it stood before the write.
		req(1'h1, BANK_PHY_MII, OFF_ADVERT, 16'hFFFF);
		@(negedge clk);
		wr = 1'h1;
		rd = 1'h1;
		wdata = 16'h0000;
		@(negedge clk);
		wr = 1'h0;
		rd = 1'h0;
		chk("adv pre-write", 16'h05E1, rdata);
		rc(BANK_PHY_MII, OFF_ADVERT, 16'h0001);
		$display("test control done");
		// Every result code, the last one through a line that never answers.
		for (i = 0; i < 5; i++) begin
			repeat (4) @(negedge clk);
			n = $random(seed);
			mres = i[1:0];
			mnear = n[9];
			mcnt = n[8:0];
			dly = {4'h0, n[13:10]} + 8'h02;
			hang = (i == 4);
			req(1'h1, BANK_CABLE_DIAG, OFF_DIAG, 16'h8000);
			chk("run", 16'h0001, {15'h0000, drun});
			// A second start while the test runs is refused and must not disturb it.
			req(1'h1, BANK_CABLE_DIAG, OFF_DIAG, 16'h8000);
			chk("run held", 16'h0001, {15'h0000, drun});
			req(1'h0, BANK_CABLE_DIAG, OFF_DIAG, 16'h0000);
			chk("busy", 16'h0001, {15'h0000, got[15]});
			for (k = 0; k < 200 && got[15] !== 1'h0; k++) begin
				req(1'h0, BANK_CABLE_DIAG, OFF_DIAG, 16'h0000);
			end
			if (got[15] !== 1'h0) begin
				mismatches = mismatches + 1;
				$display("[FAIL] diag wait expected 0 seen %h", got[15]);
				close_out();
			end
			chk("diag", hang ? 16'h6000 : {1'h0, mres, mnear, 3'h0, mcnt}, got);
		end
		$display("test diag done");
		close_out();
	end
endmodule
